// File: src/dct_map.svh
// Purpose: register indices, field positions, reset values and counts of the timer block
// Assumes: byte address of a register is four times its index
// Notes: definitions only
`ifndef DCT_MAP_SVH
`define DCT_MAP_SVH

`define DCT_IDX_T8_CTL 4'h0
`define DCT_IDX_SH_CTL 4'h1
`define DCT_IDX_T8_LOW_HOLD 4'h4
`define DCT_IDX_T8_HIGH_HOLD 4'h5
`define DCT_IDX_T16_LOW_HOLD 4'h6
`define DCT_IDX_T16_HIGH_HOLD 4'h7
`define DCT_IDX_CAP16_LOW 4'h8
`define DCT_IDX_CAP16_HIGH 4'h9
`define DCT_IDX_CAP8_LOW 4'ha
`define DCT_IDX_CAP8_HIGH 4'hb
`define DCT_IDX_IRQ_STATUS 4'hc
`define DCT_IDX_IRQ_MASK 4'hd
`define DCT_IDX_PORT3_CFG 4'he

`define DCT_T8_RUN 7
`define DCT_T8_SINGLE 6
`define DCT_T8_TIMEOUT 5
`define DCT_T8_CLK_HI 4
`define DCT_T8_CLK_LO 3
`define DCT_T8_CAP_MASK 2
`define DCT_T8_CNT_MASK 1
`define DCT_T8_P34_SEL 0

`define DCT_SH_MODE 7
`define DCT_SH_P36_DMD 6
`define DCT_SH_LOGIC_HI 5
`define DCT_SH_LOGIC_LO 4
`define DCT_SH_SUB_HI 3
`define DCT_SH_SUB_LO 2
`define DCT_SH_INIT8 1
`define DCT_SH_INIT16 0

`define DCT_P3_EDGE_HI 7
`define DCT_P3_EDGE_LO 6
`define DCT_P3_ANALOG 1
`define DCT_P3_T16_RUN 0

`define DCT_IRQ_CAPTURE 0
`define DCT_IRQ_T8_TIMEOUT 1
`define DCT_IRQ_P31_EDGE 2
`define DCT_IRQ_P32_EDGE 3
`define DCT_IRQ_T16_TIMEOUT 4

`define DCT_RST_BYTE 8'h00
`define DCT_RST_IRQ 5'h00
`define DCT_T8_MAX 8'hff
`define DCT_T16_MAX 16'hffff
`define DCT_FILTER_SHORT 4'h4
`define DCT_FILTER_LONG 4'h8

`define DCT_EDGE_FALL 2'h0
`define DCT_EDGE_RISE 2'h1
`define DCT_EDGE_BOTH 2'h2
`define DCT_LOGIC_AND 2'h0
`define DCT_LOGIC_OR 2'h1
`define DCT_LOGIC_NOR 2'h2
`define DCT_SUB_FORCE0 2'h2
`define DCT_SUB_FORCE1 2'h3
`define DCT_FLT_4 2'h1
`define DCT_FLT_8 2'h2

`endif

// File: src/dct_pkg.sv
// Purpose: types shared by the timer block
// Assumes: nothing
// Notes: state of each module is one packed struct
package dct_pkg;

  typedef logic [7:0] dct_addr_t;
  typedef logic [7:0] dct_byte_t;

  typedef struct packed {
    dct_byte_t t8ctl;
    dct_byte_t shctl;
    dct_byte_t p3cfg;
    dct_byte_t h8l;
    dct_byte_t h8h;
    dct_byte_t h16l;
    dct_byte_t h16h;
    dct_byte_t c16l;
    dct_byte_t c16h;
    dct_byte_t c8l;
    dct_byte_t c8h;
    logic [4:0] stat;
    logic [4:0] mask;
    logic [1:0] eflag;
    dct_byte_t t8_cnt;
    logic [15:0] t16_cnt;
    logic timer8_output;
    logic timer16_output;
    logic t8_run_q;
    logic t16_run_q;
    logic flt_val;
    logic [3:0] flt_cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic p34;
    logic p35;
    logic p36;
    logic cmp_en;
  } dct_top_s;

  typedef struct packed {
    logic [2:0] prev;
  } dct_edge_s;

  typedef struct packed {
    logic [2:0] cnt;
  } dct_div_s;

endpackage : dct_pkg

// File: src/dct_clk_div.sv
// Purpose: prescaler giving a one-cycle count enable at pclk, /2, /4 or /8
// Assumes: divider restarts while the timer is stopped
// Notes: none
`timescale 1ns/1ps
module dct_clk_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [1:0] sel,
  output logic tick
);
  import dct_pkg::*;

  dct_div_s s_r;
  dct_div_s s_nxt;
  logic [2:0] lim;

  always_comb begin
    s_nxt = s_r;
    lim = 3'((4'h1 << sel) - 4'h1);
    tick = run && ((s_r.cnt & lim) == lim);
    if (!run) begin
      s_nxt.cnt = 3'h0;
    end else begin
      s_nxt.cnt = 3'(s_r.cnt + 3'h1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : dct_clk_div

// File: src/dct_edge_det.sv
// Purpose: per-channel edge detector, falling, rising or both
// Assumes: inputs synchronous to pclk
// Notes: a high input at release of reset reads as one rising edge
`timescale 1ns/1ps
module dct_edge_det (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] sig,
  input wire logic [5:0] sel,
  input wire logic [2:0] en,
  output logic [2:0] rise,
  output logic [2:0] fall,
  output logic [2:0] hit
);
  import dct_pkg::*;

  `include "dct_map.svh"

  dct_edge_s s_r;
  dct_edge_s s_nxt;

  assign s_nxt.prev = sig;

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_ch
      assign rise[i] = en[i] && sig[i] && !s_r.prev[i];
      assign fall[i] = en[i] && !sig[i] && s_r.prev[i];
      assign hit[i] = (sel[2*i+1 -: 2] == `DCT_EDGE_FALL) ? fall[i] :
                      (sel[2*i+1 -: 2] == `DCT_EDGE_RISE) ? rise[i] :
                      (sel[2*i+1 -: 2] == `DCT_EDGE_BOTH) ? (rise[i] | fall[i]) : 1'b0;
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : dct_edge_det

// File: src/dct_top.sv
// Purpose: 8/16-bit counter/timer register front end with port 3 routing, APB slave
// Assumes: pins synchronous to pclk; comparators live outside and report digital results
// Notes: one wait state on every APB access
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module dct_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire dct_pkg::dct_addr_t paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port3_bit1,
  input wire logic port3_bit2,
  input wire logic comparator1_result,
  input wire logic comparator2_result,
  input wire logic port2_bit0,
  input wire logic port3_bit4_data,
  input wire logic port3_bit6_data,
  output logic comparator_enable,
  output logic port3_bit4,
  output logic port3_bit5,
  output logic port3_bit6,
  output logic irq
);
  import dct_pkg::*;

  `include "dct_map.svh"

  dct_top_s s_r;
  dct_top_s s_nxt;

  logic [3:0] idx;
  logic mapped;
  logic acc;
  logic wr;
  logic rclr;
  dct_byte_t wd;
  dct_byte_t rd;
  logic demod;
  logic p31_in;
  logic p32_in;
  logic raw_dmd;
  logic [3:0] flt_len;
  logic t8_tick;
  logic [2:0] e_rise;
  logic [2:0] e_fall;
  logic [2:0] e_hit;
  logic [2:0] e_en;
  logic [4:0] ev;
  logic cap_ev;
  logic t8_to;
  logic t16_to;
  logic t8_start;
  logic t16_start;
  logic t8_run;
  logic t16_run;
  logic comb_out;

  assign demod = s_r.shctl[`DCT_SH_MODE];
  assign t8_run = s_r.t8ctl[`DCT_T8_RUN];
  assign t16_run = s_r.p3cfg[`DCT_P3_T16_RUN];

  assign p31_in = s_r.p3cfg[`DCT_P3_ANALOG] ? comparator1_result : port3_bit1;
  assign p32_in = s_r.p3cfg[`DCT_P3_ANALOG] ? comparator2_result : port3_bit2;

  assign raw_dmd = s_r.shctl[`DCT_SH_P36_DMD] ? port2_bit0 : p31_in;

  assign e_en = {demod && (t8_run || t16_run), 2'b11};

  dct_clk_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(t8_run || t16_run),
    .sel(s_r.t8ctl[`DCT_T8_CLK_HI:`DCT_T8_CLK_LO]),
    .tick(t8_tick)
  );

  dct_edge_det u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .sig({s_r.flt_val, p32_in, p31_in}),
    .sel({s_r.shctl[`DCT_SH_LOGIC_HI:`DCT_SH_LOGIC_LO],
          s_r.p3cfg[`DCT_P3_EDGE_HI:`DCT_P3_EDGE_LO],
          s_r.p3cfg[`DCT_P3_EDGE_HI:`DCT_P3_EDGE_LO]}),
    .en(e_en),
    .rise(e_rise),
    .fall(e_fall),
    .hit(e_hit)
  );

  always_comb begin
    s_nxt = s_r;
    idx = paddr[5:2];
    wd = pwdata[7:0];
    acc = psel && penable;
    rd = 8'h00;
    ev = 5'h00;
    cap_ev = 1'b0;
    t8_to = 1'b0;
    t16_to = 1'b0;
    comb_out = 1'b0;
    flt_len = 4'h0;
    t8_start = t8_run && !s_r.t8_run_q;
    t16_start = t16_run && !s_r.t16_run_q;
    mapped = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0) &&
             (idx != 4'h2) && (idx != 4'h3) && (idx != 4'hf);

    unique case (idx)
      `DCT_IDX_T8_CTL: rd = s_r.t8ctl;
      `DCT_IDX_SH_CTL: rd = {s_r.shctl[7:2], demod ? s_r.eflag : s_r.shctl[1:0]};
      `DCT_IDX_T8_LOW_HOLD: rd = s_r.h8l;
      `DCT_IDX_T8_HIGH_HOLD: rd = s_r.h8h;
      `DCT_IDX_T16_LOW_HOLD: rd = s_r.h16l;
      `DCT_IDX_T16_HIGH_HOLD: rd = s_r.h16h;
      `DCT_IDX_CAP16_LOW: rd = s_r.c16l;
      `DCT_IDX_CAP16_HIGH: rd = s_r.c16h;
      `DCT_IDX_CAP8_LOW: rd = s_r.c8l;
      `DCT_IDX_CAP8_HIGH: rd = s_r.c8h;
      `DCT_IDX_IRQ_STATUS: rd = {3'h0, s_r.stat};
      `DCT_IDX_IRQ_MASK: rd = {3'h0, s_r.mask};
      `DCT_IDX_PORT3_CFG: rd = s_r.p3cfg;
      default: rd = 8'h00;
    endcase

    // answer one cycle into the access phase so prdata comes from a flop
    if (acc && !s_r.pready) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = !mapped;
      // read data stands until the next read answer, writes leave it alone
      if (!pwrite) begin
        s_nxt.prdata = mapped ? {24'h0, rd} : 32'h0;
      end
    end else begin
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
    end
    wr = acc && s_r.pready && pwrite && !s_r.pslverr;
    rclr = acc && s_r.pready && !pwrite && !s_r.pslverr && (idx == `DCT_IDX_IRQ_STATUS);

    if (wr) begin
      unique case (idx)
        `DCT_IDX_T8_CTL: begin
          // timeout flag is write-one-to-clear
          s_nxt.t8ctl = {wd[7:6], s_r.t8ctl[`DCT_T8_TIMEOUT] && !wd[`DCT_T8_TIMEOUT], wd[4:0]};
        end
        `DCT_IDX_SH_CTL: begin
          if (demod) begin
            s_nxt.shctl = {wd[7:2], s_r.shctl[1:0]};
            s_nxt.eflag = s_r.eflag & ~wd[1:0];
          end else begin
            s_nxt.shctl = wd;
          end
        end
        `DCT_IDX_T8_LOW_HOLD: s_nxt.h8l = wd;
        `DCT_IDX_T8_HIGH_HOLD: s_nxt.h8h = wd;
        `DCT_IDX_T16_LOW_HOLD: s_nxt.h16l = wd;
        `DCT_IDX_T16_HIGH_HOLD: s_nxt.h16h = wd;
        `DCT_IDX_IRQ_MASK: s_nxt.mask = wd[4:0];
        `DCT_IDX_PORT3_CFG: s_nxt.p3cfg = wd;
        default: s_nxt.t8ctl = s_nxt.t8ctl;
      endcase
    end

    // glitch filter: a new level must hold for the full length before it counts
    if (demod && (s_r.shctl[`DCT_SH_SUB_HI:`DCT_SH_SUB_LO] == `DCT_FLT_4)) begin
      flt_len = `DCT_FILTER_SHORT;
    end else if (demod && (s_r.shctl[`DCT_SH_SUB_HI:`DCT_SH_SUB_LO] == `DCT_FLT_8)) begin
      flt_len = `DCT_FILTER_LONG;
    end
    if (raw_dmd == s_r.flt_val) begin
      s_nxt.flt_cnt = 4'h0;
    end else if ((flt_len == 4'h0) || (4'(s_r.flt_cnt + 4'h1) >= flt_len)) begin
      s_nxt.flt_val = raw_dmd;
      s_nxt.flt_cnt = 4'h0;
    end else begin
      s_nxt.flt_cnt = 4'(s_r.flt_cnt + 4'h1);
    end

    // eight-bit timer
    s_nxt.t8_run_q = t8_run;
    if (!demod) begin
      if (t8_start) begin
        s_nxt.timer8_output = s_r.shctl[`DCT_SH_INIT8];
        s_nxt.t8_cnt = s_r.shctl[`DCT_SH_INIT8] ? s_r.h8h : s_r.h8l;
      end else if (t8_tick && t8_run) begin
        if (s_r.t8_cnt == 8'h00) begin
          t8_to = 1'b1;
          s_nxt.timer8_output = !s_r.timer8_output;
          s_nxt.t8_cnt = s_r.timer8_output ? s_r.h8l : s_r.h8h;
          if (s_r.t8ctl[`DCT_T8_SINGLE]) begin
            s_nxt.t8ctl[`DCT_T8_RUN] = 1'b0;
          end
        end else begin
          s_nxt.t8_cnt = 8'(s_r.t8_cnt - 8'h01);
        end
      end
    end else if (t8_run) begin
      if (e_hit[2]) begin
        cap_ev = 1'b1;
        // rising edge ends a low period
        if (e_rise[2]) begin
          s_nxt.c8l = s_r.t8_cnt;
        end
        // falling edge ends a high period
        if (e_fall[2]) begin
          s_nxt.c8h = s_r.t8_cnt;
        end
        s_nxt.t8_cnt = `DCT_T8_MAX;
      end else if (t8_tick) begin
        if (s_r.t8_cnt == 8'h00) begin
          t8_to = 1'b1;
          s_nxt.t8_cnt = `DCT_T8_MAX;
        end else begin
          s_nxt.t8_cnt = 8'(s_r.t8_cnt - 8'h01);
        end
      end
    end
    // edge status flags, set wins over clear
    if (demod && e_hit[2]) begin
      s_nxt.eflag = s_nxt.eflag | {e_rise[2], e_fall[2]};
    end
    // timeout flag, set wins over clear
    if (t8_to) begin
      s_nxt.t8ctl[`DCT_T8_TIMEOUT] = 1'b1;
    end

    // sixteen-bit timer
    s_nxt.t16_run_q = t16_run;
    if (!demod) begin
      if (t16_start) begin
        s_nxt.timer16_output = s_r.shctl[`DCT_SH_INIT16];
        s_nxt.t16_cnt = {s_r.h16h, s_r.h16l};
      end else if (t8_tick && t16_run) begin
        if (s_r.t16_cnt == 16'h0000) begin
          t16_to = 1'b1;
          s_nxt.timer16_output = !s_r.timer16_output;
          s_nxt.t16_cnt = {s_r.h16h, s_r.h16l};
        end else begin
          s_nxt.t16_cnt = 16'(s_r.t16_cnt - 16'h0001);
        end
      end
      if (s_r.shctl[`DCT_SH_SUB_HI:`DCT_SH_SUB_LO] == `DCT_SUB_FORCE0) begin
        s_nxt.timer16_output = 1'b0;
      end else if (s_r.shctl[`DCT_SH_SUB_HI:`DCT_SH_SUB_LO] == `DCT_SUB_FORCE1) begin
        s_nxt.timer16_output = 1'b1;
      end
    end else if (t16_run) begin
      if (e_hit[2]) begin
        s_nxt.c16h = s_r.t16_cnt[15:8];
        s_nxt.c16l = s_r.t16_cnt[7:0];
        s_nxt.t16_cnt = {s_r.h16h, s_r.h16l};
      end else if (t8_tick) begin
        if (s_r.t16_cnt == 16'h0000) begin
          t16_to = 1'b1;
          s_nxt.t16_cnt = `DCT_T16_MAX;
        end else begin
          s_nxt.t16_cnt = 16'(s_r.t16_cnt - 16'h0001);
        end
      end
    end

    ev[`DCT_IRQ_CAPTURE] = cap_ev && s_r.t8ctl[`DCT_T8_CAP_MASK];
    ev[`DCT_IRQ_T8_TIMEOUT] = t8_to && s_r.t8ctl[`DCT_T8_CNT_MASK];
    ev[`DCT_IRQ_P31_EDGE] = e_hit[0];
    ev[`DCT_IRQ_P32_EDGE] = e_hit[1];
    ev[`DCT_IRQ_T16_TIMEOUT] = t16_to;
    // only bits actually returned by the read are cleared; new events win
    s_nxt.stat = (s_r.stat & ~(rclr ? s_r.prdata[4:0] : 5'h00)) | ev;
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);

    unique case (s_r.shctl[`DCT_SH_LOGIC_HI:`DCT_SH_LOGIC_LO])
      `DCT_LOGIC_AND: comb_out = s_r.timer8_output & s_r.timer16_output;
      `DCT_LOGIC_OR: comb_out = s_r.timer8_output | s_r.timer16_output;
      `DCT_LOGIC_NOR: comb_out = !(s_r.timer8_output | s_r.timer16_output);
      default: comb_out = !(s_r.timer8_output & s_r.timer16_output);
    endcase
    s_nxt.p34 = s_r.t8ctl[`DCT_T8_P34_SEL] ? s_r.timer8_output : port3_bit4_data;
    s_nxt.p35 = s_r.timer16_output;
    s_nxt.p36 = (!demod && s_r.shctl[`DCT_SH_P36_DMD]) ? comb_out : port3_bit6_data;
    s_nxt.cmp_en = s_r.p3cfg[`DCT_P3_ANALOG];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign comparator_enable = s_r.cmp_en;
  assign port3_bit4 = s_r.p34;
  assign port3_bit5 = s_r.p35;
  assign port3_bit6 = s_r.p36;
  assign irq = s_r.irq;

endmodule : dct_top

// File: tb/dct_top_checker.sv
// Purpose: bus timing and pin routing checks for the timer block
// Assumes: shadow bits follow completed APB writes
// Notes: bound to dct_top at the foot of this file
`timescale 1ns/1ps
module dct_top_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire dct_pkg::dct_addr_t paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic port3_bit1,
  input wire logic port3_bit2,
  input wire logic comparator1_result,
  input wire logic comparator2_result,
  input wire logic port2_bit0,
  input wire logic port3_bit4_data,
  input wire logic port3_bit6_data,
  input wire logic comparator_enable,
  input wire logic port3_bit4,
  input wire logic port3_bit5,
  input wire logic port3_bit6,
  input wire logic irq
);
  import dct_pkg::*;
  logic wr;
  logic bad;
  logic sel34_r;
  logic an_r;
  logic p36_r;
  logic [4:0] msk_r;
  assign wr = psel && penable && pready && pwrite && !pslverr;
  assign bad = paddr[1:0] != 2'h0 || paddr[7:6] != 2'h0 || paddr[5:2] == 4'h2
    || paddr[5:2] == 4'h3 || paddr[5:2] == 4'hf;
  // shadows only see writes that really landed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel34_r <= 1'b0;
      an_r <= 1'b0;
      p36_r <= 1'b0;
      msk_r <= 5'h00;
    end else if (wr) begin
      if (paddr == 8'h00) sel34_r <= pwdata[0];
      if (paddr == 8'h04) p36_r <= !pwdata[7] && pwdata[6];
      if (paddr == 8'h38) an_r <= pwdata[1];
      if (paddr == 8'h34) msk_r <= pwdata[4:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("answer not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_decode: assert property (pready |-> pslverr == bad)
    else $error("error flag disagrees with address");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_rd_upper: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_rd_hold: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("read data moved outside a read");
  a_cmp_follow: assert property (comparator_enable == $past(an_r))
    else $error("comparator enable wrong");
  a_p34_data: assert property ($past(presetn) && !$past(sel34_r) && !sel34_r
    |-> port3_bit4 == $past(port3_bit4_data)) else $error("bit4 port data lost");
  a_p36_data: assert property ($past(presetn) && !$past(p36_r) && !p36_r
    |-> port3_bit6 == $past(port3_bit6_data)) else $error("bit6 port data lost");
  a_irq_masked: assert property ($past(msk_r) == 5'h0 && msk_r == 5'h0 |-> !irq)
    else $error("interrupt while all masked");
endmodule : dct_top_checker

bind dct_top dct_top_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .port3_bit1(port3_bit1), .port3_bit2(port3_bit2),
  .comparator1_result(comparator1_result), .comparator2_result(comparator2_result),
  .port2_bit0(port2_bit0), .port3_bit4_data(port3_bit4_data),
  .port3_bit6_data(port3_bit6_data), .comparator_enable(comparator_enable),
  .port3_bit4(port3_bit4), .port3_bit5(port3_bit5), .port3_bit6(port3_bit6), .irq(irq));

// File: tb/dct_pins.sv
// Purpose: pin side of port 3, port 2 bit 0 and the comparators
// Assumes: bench asks for levels; pins move just after a rising edge
// Notes: want/pin order p31, p32, cmp1, cmp2, p20, bit4 data, bit6 data
`timescale 1ns/1ps
module dct_pins (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cen,
  input wire logic [6:0] want,
  output logic [6:0] pin
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin <= 7'h00;
    end else begin
      // unpowered comparators give no stable level
      pin <= cen ? want : {want[6:4], ~pin[3:2], want[1:0]};
    end
  end
endmodule : dct_pins

// File: tb/dct_top_tb.sv
// Purpose: register and pin scenarios for the timer block
// Assumes: one wait state; byte address is four times the index
// Notes: capture checked by difference, so pipeline depth cancels
`timescale 1ns/1ps
`include "dct_map.svh"
module dct_top_tb;
  import dct_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cen, p34, p35, p36, irq, e;
  dct_addr_t paddr;
  logic [31:0] pwdata, prdata, r;
  logic [6:0] want, pin;
  logic [7:0] hi;
  int n_mismatch, total_checks, k;
  always #50 pclk = ~pclk;
  dct_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port3_bit1(pin[0]), .port3_bit2(pin[1]),
    .comparator1_result(pin[2]), .comparator2_result(pin[3]), .port2_bit0(pin[4]),
    .port3_bit4_data(pin[5]), .port3_bit6_data(pin[6]), .comparator_enable(cen),
    .port3_bit4(p34), .port3_bit5(p35), .port3_bit6(p36), .irq(irq));
  dct_pins pins (.pclk(pclk), .presetn(presetn), .cen(cen), .want(want), .pin(pin));
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic apb(input logic w, input dct_addr_t a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) chk("bus answer", 1, 0);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    apb(1'b1, {2'h0, i, 2'h0}, d);
  endtask : wr
  task automatic rd(input logic [3:0] i, input logic [7:0] m, input logic [7:0] x,
    input string nm);
    apb(1'b0, {2'h0, i, 2'h0}, 8'h00);
    chk(nm, {24'h0, x}, r & {24'h0, m});
  endtask : rd
  task automatic pn(input logic [6:0] v, input int n);
    @(posedge pclk);
    want <= v;
    cyc(n);
  endtask : pn
  initial begin
    repeat (20000) @(posedge pclk);
    chk("watchdog", 0, 1);
    results();
  end
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 8'h00; pwdata = 32'h0; want = 7'h00;
    cyc(5);
    presetn <= 1'b1;
    for (k = 0; k < 15; k++) if (k != 2 && k != 3) rd(4'(k), 8'hff, 8'h00, "reset");
    for (k = 4; k < 8; k++) wr(4'(k), 8'(k * 17));
    for (k = 4; k < 8; k++) rd(4'(k), 8'hff, 8'(k * 17), "hold");
    for (k = 8; k < 12; k++) wr(4'(k), 8'hff);
    for (k = 8; k < 12; k++) rd(4'(k), 8'hff, 8'h00, "capture write");
    apb(1'b0, 8'h08, 8'h00);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, r);
    $display("done: registers");
    wr(`DCT_IDX_IRQ_MASK, 8'h01);
    wr(`DCT_IDX_T8_CTL, 8'h84);
    wr(`DCT_IDX_SH_CTL, 8'ha0);
    pn(7'h01, 20);
    pn(7'h00, 40);
    pn(7'h01, 10);
    rd(`DCT_IDX_SH_CTL, 8'h03, 8'h03, "edge flags");
    apb(1'b0, 8'h2c, 8'h00);
    hi = r[7:0];
    apb(1'b0, 8'h28, 8'h00);
    chk("high minus low", 8'd20, 8'(hi - r[7:0]));
    chk("irq raised", 1, irq);
    wr(`DCT_IDX_IRQ_MASK, 8'h00);
    cyc(2);
    chk("irq masked", 0, irq);
    wr(`DCT_IDX_IRQ_MASK, 8'h01);
    cyc(2);
    chk("irq unmasked", 1, irq);
    rd(`DCT_IDX_IRQ_STATUS, 8'h01, 8'h01, "capture status");
    cyc(2);
    chk("irq cleared", 0, irq);
    wr(`DCT_IDX_SH_CTL, 8'he3);
    // source switch from a high pin to a low one reads as a falling edge
    wr(`DCT_IDX_SH_CTL, 8'he3);
    pn(7'h00, 5);
    pn(7'h01, 5);
    rd(`DCT_IDX_SH_CTL, 8'h03, 8'h00, "bit1 ignored");
    wr(`DCT_IDX_PORT3_CFG, 8'h01);
    pn(7'h10, 8);
    rd(`DCT_IDX_SH_CTL, 8'h03, 8'h02, "p20 rise");
    pn(7'h00, 8);
    rd(`DCT_IDX_SH_CTL, 8'h03, 8'h03, "p20 fall");
    apb(1'b0, 8'h2c, 8'h00);
    hi = r[7:0];
    apb(1'b0, 8'h20, 8'h00);
    chk("cap16 low vs cap8", 8'h99, 8'(hi - r[7:0]));
    rd(`DCT_IDX_CAP16_HIGH, 8'hff, 8'h77, "cap16 high");
    $display("done: demodulation");
    wr(`DCT_IDX_T8_CTL, 8'h82);
    wr(`DCT_IDX_IRQ_MASK, 8'h02);
    cyc(300);
    rd(`DCT_IDX_T8_CTL, 8'h20, 8'h20, "timeout flag");
    chk("timeout irq", 1, irq);
    rd(`DCT_IDX_IRQ_STATUS, 8'h02, 8'h02, "timeout status");
    wr(`DCT_IDX_T8_CTL, 8'h20);
    rd(`DCT_IDX_T8_CTL, 8'h20, 8'h00, "timeout clear");
    wr(`DCT_IDX_IRQ_MASK, 8'h00);
    $display("done: timeout");
    wr(`DCT_IDX_SH_CTL, 8'h00);
    for (k = 0; k < 3; k++) begin
      wr(`DCT_IDX_PORT3_CFG, 8'(k * 64));
      apb(1'b0, 8'h30, 8'h00);
      pn(7'h02, 6);
      rd(`DCT_IDX_IRQ_STATUS, 8'h08, {4'h0, 1'(3'b110 >> k), 3'h0}, "p32 rise");
      pn(7'h00, 6);
      rd(`DCT_IDX_IRQ_STATUS, 8'h08, {4'h0, 1'(3'b101 >> k), 3'h0}, "p32 fall");
    end
    wr(`DCT_IDX_PORT3_CFG, 8'h42);
    apb(1'b0, 8'h30, 8'h00);
    chk("comparator on", 1, cen);
    pn(7'h08, 6);
    rd(`DCT_IDX_IRQ_STATUS, 8'h08, 8'h08, "comparator edge");
    pn(7'h00, 2);
    wr(`DCT_IDX_PORT3_CFG, 8'h00);
    $display("done: pin edges");
    wr(`DCT_IDX_T8_HIGH_HOLD, 8'h14);
    wr(`DCT_IDX_T16_HIGH_HOLD, 8'h01);
    wr(`DCT_IDX_T16_LOW_HOLD, 8'h00);
    wr(`DCT_IDX_SH_CTL, 8'h43);
    wr(`DCT_IDX_PORT3_CFG, 8'h01);
    wr(`DCT_IDX_T8_CTL, 8'hc1);
    cyc(5);
    chk("t8 start", 1, p34);
    chk("t16 start", 1, p35);
    chk("and out", 1, p36);
    cyc(40);
    chk("t8 done", 0, p34);
    chk("and low", 0, p36);
    wr(`DCT_IDX_T8_CTL, 8'h00);
    pn(7'h20, 3);
    chk("port data", 1, p34);
    $display("done: transmit");
    results();
  end
endmodule : dct_top_tb
